// ===== logic/szt_core.sv
// weighing-function logic with an ahb-lite register slave
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module szt_core
  import szt_pkg::*;
#(
  parameter int unsigned MS_DIV = CYC_PER_MS
) (
  // ahb-lite
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // indicators
  output logic             net_led,
  output logic             func_led,
  output logic [2:0]       msg_code,
  output logic [15:0]      dac_code
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic       wr_q, rd_q;
  logic [7:0] adr_q;
  wire  take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      wr_q  <= take && hwrite;
      rd_q  <= take && !hwrite;
      if (take) adr_q <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire w_ctrl   = wr_q && adr_q == OFS_CTRL;
  wire w_cmd    = wr_q && adr_q == OFS_CMD;
  wire w_weight = wr_q && adr_q == OFS_WEIGHT;
  wire w_zlim   = wr_q && adr_q == OFS_ZLIM;
  wire w_track  = wr_q && adr_q == OFS_TRACK;
  wire w_stab   = wr_q && adr_q == OFS_STAB;
  wire w_ptare  = wr_q && adr_q == OFS_PTARE;
  wire w_factor = wr_q && adr_q == OFS_FACTOR;
  wire w_check  = wr_q && adr_q == OFS_CHECK;
  wire w_szero  = wr_q && adr_q == OFS_SZERO;
  wire [12:0] cmd = w_cmd ? hwdata[12:0] : 13'h0000;

  // ----------------------------------------------------------------
  // configuration
  // ctrl: 0 approved, 1 zero restore, 2 auto zero, 3 save key enable,
  // 4 current output, 5 pounds, 6 overload, 7 underload, 8 erase enable
  // ----------------------------------------------------------------
  logic [8:0]  ctrl_q;
  logic [23:0] raw_q, zlim_q, ptare_q, szero_q, factor_q;
  logic [25:0] chk_q;
  logic [7:0]  trk_div_q, stab_div_q;
  logic [12:0] trk_dly_q, stab_ms_q;

  wire approved = ctrl_q[0];
  wire overload = ctrl_q[6];
  wire underload = ctrl_q[7];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q     <= 9'h000;
      raw_q      <= 24'h000000;
      zlim_q     <= 24'h000000;
      ptare_q    <= 24'h000000;
      szero_q    <= 24'h000000;
      factor_q   <= 24'h000400;
      chk_q      <= 26'h0000000;
      trk_div_q  <= 8'h00;
      stab_div_q <= 8'h02;
      trk_dly_q  <= 13'(TRACK_DLY_RST);
      stab_ms_q  <= 13'(STAB_MS_RST);
    end else begin
      if (w_ctrl)   ctrl_q   <= hwdata[8:0];
      if (w_weight) raw_q    <= hwdata[23:0];
      if (w_zlim)   zlim_q   <= hwdata[23:0];
      if (w_ptare)  ptare_q  <= hwdata[23:0];
      if (w_szero)  szero_q  <= hwdata[23:0];
      if (w_factor) factor_q <= hwdata[23:0];
      if (w_check)  chk_q    <= hwdata[25:0];
      if (w_track) begin
        trk_div_q <= hwdata[7:0];
        // clamp the delay into its legal span
        if (hwdata[28:16] < 13'(TRACK_DLY_MIN))      trk_dly_q <= 13'(TRACK_DLY_MIN);
        else if (hwdata[28:16] > 13'(TRACK_DLY_MAX)) trk_dly_q <= 13'(TRACK_DLY_MAX);
        else                                         trk_dly_q <= hwdata[28:16];
      end
      if (w_stab) begin
        stab_div_q <= hwdata[7:0];
        stab_ms_q  <= hwdata[28:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // timebase and stability
  // ----------------------------------------------------------------
  logic ms_tick;

  szt_tick #(.DIV(MS_DIV)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ms_tick (ms_tick)
  );

  logic signed [24:0] zero_q, tare_q, ref_q;
  logic        [12:0] stab_cnt_q;
  logic               stable_q;
  wire  signed [24:0] raw_s = $signed({1'b0, raw_q});
  wire  signed [24:0] gross = raw_s - zero_q;
  // stability follows the load itself, so a zero step does not upset it
  wire  signed [24:0] dev   = raw_s - ref_q;
  wire         [24:0] adev  = dev[24] ? 25'(-dev) : dev;
  wire         [12:0] stab_need = approved ? 13'(STAB_MS_APPR) : stab_ms_q;
  wire                in_band = (stab_div_q == 8'h00) || (adev <= {17'h0, stab_div_q});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_q      <= 25'sh0;
      stab_cnt_q <= 13'h0000;
      stable_q   <= 1'b0;
    end else if (!in_band) begin
      ref_q      <= raw_s;
      stab_cnt_q <= 13'h0000;
      stable_q   <= 1'b0;
    end else if (ms_tick && stab_cnt_q < stab_need) begin
      stab_cnt_q <= stab_cnt_q + 13'h0001;
    end else if (stab_cnt_q >= stab_need) begin
      stable_q   <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // request decode against one captured sample
  // ----------------------------------------------------------------
  wire signed [24:0] smp = gross;
  wire signed [24:0] net = smp - tare_q;
  wire        neg  = smp[24];
  wire [24:0] amag = neg ? 25'(-smp) : smp;
  // a zero request on a negative net only drops the tare
  wire zero_neg   = (cmd[CMD_ZERO] || cmd[CMD_ZERO_NS])
                    && tare_q != 25'sh0 && net[24];
  wire do_zero    = (cmd[CMD_ZERO] && stable_q || cmd[CMD_ZERO_NS])
                    && amag <= {1'b0, zlim_q} && !zero_neg;
  wire unloaded   = smp < 25'sd1;
  wire do_tare    = cmd[CMD_TARE] && !overload && !unloaded;
  wire clr_tare   = cmd[CMD_TARE] && unloaded && !overload;
  wire save_ok    = !neg && stable_q && !overload && !underload
                    && (!approved || smp > 25'(SAVE_MIN_DIV));
  wire save_req   = cmd[CMD_SAVE] || (cmd[CMD_SAVE_KEY] && ctrl_q[3]);

  // ----------------------------------------------------------------
  // zero, tracking and tare
  // ----------------------------------------------------------------
  logic [12:0] trk_ms_q;
  logic [9:0]  sec_q;
  wire         sec_tick = ms_tick && sec_q == 10'(TRACK_PERIOD_MS - 1);
  wire         trk_ok  = stable_q && trk_ms_q >= trk_dly_q && trk_div_q != 8'h00
                         && amag <= {17'h0, trk_div_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_q    <= 10'h000;
      trk_ms_q <= 13'h0000;
    end else begin
      if (ms_tick) sec_q <= sec_tick ? 10'h000 : sec_q + 10'h001;
      if (!stable_q)                              trk_ms_q <= 13'h0000;
      else if (ms_tick && trk_ms_q < trk_dly_q)   trk_ms_q <= trk_ms_q + 13'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_q <= 25'sh0;
      tare_q <= 25'sh0;
    end else begin
      if (cmd[CMD_POWERUP] && ctrl_q[1] && (!ctrl_q[2] || cmd[CMD_AZ_FAIL]))
        zero_q <= $signed({1'b0, szero_q});
      else if (do_zero)
        zero_q <= zero_q + smp;
      else if (sec_tick && trk_ok)
        zero_q <= zero_q + smp;
      if (zero_neg || clr_tare)                 tare_q <= 25'sh0;
      else if (do_tare)                         tare_q <= smp;
      else if (cmd[CMD_PTARE])                  tare_q <= $signed({1'b0, ptare_q});
    end
  end

  assign net_led = tare_q != 25'sh0;

  // ----------------------------------------------------------------
  // alibi identifier
  // ----------------------------------------------------------------
  logic [17:0] wcnt_q;
  logic [7:0]  rcnt_q;
  logic        saved_q, result_ok_q, any_rec_q, verify_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wcnt_q      <= 18'h00000;
      rcnt_q      <= 8'h00;
      saved_q     <= 1'b0;
      result_ok_q <= 1'b0;
      any_rec_q   <= 1'b0;
    end else if (cmd[CMD_ERASE] && ctrl_q[8] && !approved) begin
      wcnt_q    <= 18'h00000;
      rcnt_q    <= 8'h00;
      any_rec_q <= 1'b0;
      saved_q   <= 1'b0;
    end else if (save_req) begin
      saved_q     <= cmd[CMD_SAVE] || save_ok;
      result_ok_q <= save_ok;
      if (save_ok) begin
        any_rec_q <= 1'b1;
        if (wcnt_q == 18'(WCNT_MAX)) begin
          wcnt_q <= 18'h00000;
          rcnt_q <= (rcnt_q == 8'(RCNT_MAX)) ? 8'h00 : rcnt_q + 8'h01;
        end else begin
          wcnt_q <= wcnt_q + 18'h00001;
        end
      end
    end
  end

  // check register: rewrite count in [25:18], weighing count in [17:0]
  wire [7:0]  c_rw = chk_q[25:18];
  wire [17:0] c_wn = chk_q[17:0];
  wire        valid_id = (c_rw == rcnt_q && c_wn <= wcnt_q)
                         || (rcnt_q != 8'h00 && c_rw == rcnt_q - 8'h01 && c_wn > wcnt_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) verify_q <= 1'b0;
    else if (cmd[CMD_CHECK]) verify_q <= any_rec_q && valid_id;
  end

  // ----------------------------------------------------------------
  // use functions and messages
  // ----------------------------------------------------------------
  logic        hires_q, peak_q, unit_q;
  logic [12:0] hr_ms_q, pk_ms_q, msg_ms_q;
  logic signed [24:0] peak_val_q;
  szt_msg_t    msg_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hires_q    <= 1'b0;
      peak_q     <= 1'b0;
      unit_q     <= 1'b0;
      hr_ms_q    <= 13'h0000;
      pk_ms_q    <= 13'h0000;
      peak_val_q <= 25'sh0;
    end else begin
      if (cmd[CMD_HIRES]) begin
        hires_q <= !hires_q;
        hr_ms_q <= 13'h0000;
      end else if (hires_q && approved && ms_tick) begin
        if (hr_ms_q == 13'(HIRES_MS - 1)) hires_q <= 1'b0;
        hr_ms_q <= hr_ms_q + 13'h0001;
      end
      if (cmd[CMD_PEAK]) begin
        peak_q     <= !peak_q;
        peak_val_q <= net;
        pk_ms_q    <= 13'h0000;
      end else if (peak_q) begin
        if (net > peak_val_q) peak_val_q <= net;
        if (ms_tick) pk_ms_q <= (pk_ms_q == 13'(PEAK_MS - 1)) ? 13'h0000 : pk_ms_q + 13'h0001;
      end
      if (cmd[CMD_UNIT]) unit_q <= !unit_q;
    end
  end

  wire peak_banner = peak_q && ms_tick && pk_ms_q == 13'(PEAK_MS - 1);
  wire empty_read  = cmd[CMD_CHECK] && !any_rec_q;
  wire noid_read   = cmd[CMD_CHECK] && any_rec_q && !valid_id;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_q    <= SZT_MSG_NONE;
      msg_ms_q <= 13'h0000;
    end else if (do_zero || do_tare || cmd[CMD_PTARE] || empty_read || noid_read
                 || peak_banner || (cmd[CMD_PEAK] && peak_q)) begin
      msg_ms_q <= 13'h0000;
      if (do_zero)             msg_q <= SZT_MSG_ZERO;
      else if (do_tare)        msg_q <= SZT_MSG_TARE;
      else if (cmd[CMD_PTARE]) msg_q <= SZT_MSG_PTARE;
      else if (empty_read)     msg_q <= SZT_MSG_EMPTY;
      else if (noid_read)      msg_q <= SZT_MSG_NOID;
      else if (peak_banner)    msg_q <= SZT_MSG_PEAK;
      else                     msg_q <= SZT_MSG_PEAKOFF;
    end else if (msg_q != SZT_MSG_NONE && ms_tick) begin
      if (msg_ms_q == 13'(MSG_MS - 1)) msg_q <= SZT_MSG_NONE;
      msg_ms_q <= msg_ms_q + 13'h0001;
    end
  end

  assign msg_code = msg_q;
  assign func_led = hires_q || unit_q || peak_q;

  // ----------------------------------------------------------------
  // displayed value and analog code
  // ----------------------------------------------------------------
  wire signed [24:0] shown = peak_q ? peak_val_q : (tare_q != 25'sh0 ? net : smp);
  wire signed [49:0] conv  = ctrl_q[5] ? shown * $signed(25'(LB_NUM))
                                       : shown * $signed({1'b0, factor_q});
  wire signed [31:0] scaled = unit_q ? 32'(conv >>> LB_SHIFT) : 32'(shown);
  wire signed [31:0] disp   = hires_q ? 32'(scaled * 10) : scaled;
  wire        [16:0] fs     = ctrl_q[4] ? 17'(DA_FS_CURR) : 17'(DA_FS_VOLT);
  wire        [41:0] da_p   = {18'h0, (neg ? 24'h0 : smp[23:0])} * {25'h0, fs};
  wire        [41:0] da_q   = (zlim_q == 24'h0) ? 42'h0 : da_p / {18'h0, zlim_q};
  logic       [15:0] dac_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dac_q <= 16'h0000;
    else          dac_q <= (da_q > {26'h0, 16'hffff}) ? 16'hffff : da_q[15:0];
  end

  assign dac_code = dac_q;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h00000000;
    else if (take && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CTRL:   hrdata <= {23'h0, ctrl_q};
        OFS_WEIGHT: hrdata <= {8'h0, raw_q};
        OFS_ZLIM:   hrdata <= {8'h0, zlim_q};
        OFS_TRACK:  hrdata <= {3'h0, trk_dly_q, 8'h0, trk_div_q};
        OFS_STAB:   hrdata <= {3'h0, stab_ms_q, 8'h0, stab_div_q};
        OFS_PTARE:  hrdata <= {8'h0, ptare_q};
        OFS_FACTOR: hrdata <= {8'h0, factor_q};
        OFS_STATUS: hrdata <= {24'h0, verify_q, result_ok_q, saved_q, any_rec_q,
                               unit_q, peak_q, hires_q, stable_q};
        OFS_ZERO:   hrdata <= 32'(zero_q);
        OFS_TARE:   hrdata <= 32'(tare_q);
        OFS_DISP:   hrdata <= disp;
        OFS_SAVE:   hrdata <= {result_ok_q, 5'h0, rcnt_q, wcnt_q};
        OFS_CHECK:  hrdata <= {6'h0, chk_q};
        OFS_DAC:    hrdata <= {16'h0, dac_q};
        OFS_SZERO:  hrdata <= {8'h0, szero_q};
        default:    hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule : szt_core

// ===== logic/szt_pkg.sv
// package: constants and types of the weighing-function block
// What this block does
// - zero tracking removes drift each second
// - tracking waits delay after stability, within limit
// - restore stored zero per auto-zero outcome
// - zero request zeroes gross, shows message
// - zero refused over capacity or unstable
// - tare request stores weight, net indicator lit
// - tare refused below one division or overload
// - preset tare loads value; zero on negative net clears tare
// - tare cleared unloaded tare or negative zero
// - save reports result and identifier
// - id is rewrite 0-255, weighing 0-131072
// - save increments count, wraps into rewrite
// - save needs stable, valid, non-negative weight
// - refused save answers NO, key sends nothing
// - record verifiable only within issued id window
// - alibi read shows empty or invalid briefly
// - alibi erase clears counts, record and saved flags, blocked when approved
// - high resolution toggles, approved stops after 5s
// - peak holds maximum, banner every 5s
// - unit conversion scales weight, lights indicator
// - analog codes scale to 63300 and 58200 points
// - stable after band held for stability time
package szt_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned SEC_MS        = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned TRACK_PERIOD_MS = 1000;
  localparam int unsigned TRACK_DLY_MIN = 100;
  localparam int unsigned TRACK_DLY_MAX = 5000;
  localparam int unsigned TRACK_DLY_RST = 1000;
  localparam int unsigned STAB_MS_RST   = 500;
  localparam int unsigned STAB_MS_APPR  = 500;
  localparam int unsigned MSG_MS        = 1000;
  localparam int unsigned HIRES_MS      = 5000;
  localparam int unsigned PEAK_MS       = 5000;
  localparam int unsigned WCNT_MAX      = 131072;
  localparam int unsigned RCNT_MAX      = 255;
  localparam int unsigned SAVE_MIN_DIV  = 20;
  localparam int unsigned DA_FS_VOLT    = 63300;
  localparam int unsigned DA_FS_CURR    = 58200;
  localparam int unsigned LB_NUM        = 2258; // pounds per kilogram, q10
  localparam int unsigned LB_SHIFT      = 10;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_WEIGHT = 8'h08;
  localparam logic [7:0] OFS_ZLIM   = 8'h0c;
  localparam logic [7:0] OFS_TRACK  = 8'h10;
  localparam logic [7:0] OFS_STAB   = 8'h14;
  localparam logic [7:0] OFS_PTARE  = 8'h18;
  localparam logic [7:0] OFS_FACTOR = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_ZERO   = 8'h24;
  localparam logic [7:0] OFS_TARE   = 8'h28;
  localparam logic [7:0] OFS_DISP   = 8'h2c;
  localparam logic [7:0] OFS_SAVE   = 8'h30;
  localparam logic [7:0] OFS_CHECK  = 8'h34;
  localparam logic [7:0] OFS_DAC    = 8'h38;
  localparam logic [7:0] OFS_SZERO  = 8'h3c;

  // command bits in OFS_CMD
  localparam int unsigned CMD_ZERO    = 0;
  localparam int unsigned CMD_ZERO_NS = 1;
  localparam int unsigned CMD_TARE    = 2;
  localparam int unsigned CMD_PTARE   = 3;
  localparam int unsigned CMD_SAVE    = 4;
  localparam int unsigned CMD_SAVE_KEY = 5;
  localparam int unsigned CMD_HIRES   = 6;
  localparam int unsigned CMD_PEAK    = 7;
  localparam int unsigned CMD_UNIT    = 8;
  localparam int unsigned CMD_ERASE   = 9;
  localparam int unsigned CMD_CHECK   = 10;
  localparam int unsigned CMD_AZ_FAIL = 11;
  localparam int unsigned CMD_POWERUP = 12;

  typedef enum logic [2:0] {
    SZT_MSG_NONE, SZT_MSG_ZERO, SZT_MSG_TARE, SZT_MSG_PTARE,
    SZT_MSG_EMPTY, SZT_MSG_NOID, SZT_MSG_PEAK, SZT_MSG_PEAKOFF
  } szt_msg_t;

endpackage : szt_pkg

// ===== logic/szt_tick.sv
// millisecond tick divider
`timescale 1ns/1ns
module szt_tick
  import szt_pkg::*;
#(
  parameter int unsigned DIV = CYC_PER_MS
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // tick
  output logic      ms_tick
);

  logic [15:0] cnt_q;
  wire  last = (cnt_q == 16'(DIV - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= 16'h0000;
    else          cnt_q <= last ? 16'h0000 : cnt_q + 16'h0001;
  end

  assign ms_tick = last;

endmodule : szt_tick

// ===== bench/szt_core_sva.sv
// assertion checker for the weighing-function block
`timescale 1ns/1ns
module szt_core_sva
  import szt_pkg::*;
#(
  parameter int unsigned MS_DIV = CYC_PER_MS
) (
  // ahb-lite
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // indicators
  input wire logic        net_led,
  input wire logic        func_led,
  input wire logic [2:0]  msg_code,
  input wire logic [15:0] dac_code
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic        ap_q;
  logic        apw_q;
  logic [7:0]  apa_q;
  logic [31:0] ptare_q;
  logic        fac_q;
  logic [7:0]  since_q;
  wire         taken  = hsel & hready & htrans[1];
  wire         dp_wr  = ap_q & apw_q;
  wire         cmd_dp = dp_wr & (apa_q == OFS_CMD);
  wire         rd_low = taken & !hwrite & (haddr[31:8] == 24'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q    <= 1'b0;
      apw_q   <= 1'b0;
      apa_q   <= 8'h00;
      ptare_q <= 32'h0;
      fac_q   <= 1'b0;
      since_q <= 8'hff;
    end else begin
      ap_q  <= taken;
      apw_q <= hwrite;
      apa_q <= haddr[7:0];
      if (dp_wr && apa_q == OFS_PTARE) ptare_q <= hwdata;
      if (dp_wr && apa_q == OFS_FACTOR) fac_q <= 1'b1;
      since_q <= cmd_dp ? 8'h00 : (since_q == 8'hff ? since_q : since_q + 8'h01);
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_ZERO_WAIT: assert property (hreadyout)
    else $error("slave inserted a wait state");
  AST_OKAY: assert property (!hresp)
    else $error("slave gave an error response");
  AST_PTARE_SET: assert property (cmd_dp && hwdata[CMD_PTARE] && ptare_q != 0
                                  |-> ##[1:4] net_led)
    else $error("preset tare did not light net indicator");
  AST_PTARE_CLR: assert property (cmd_dp && hwdata[CMD_PTARE] && ptare_q == 0
                                  |-> ##[1:4] !net_led)
    else $error("preset tare of zero did not clear tare");
  AST_MSG_HOLD: assert property ($rose(msg_code != 3'h0) |=> (msg_code != 3'h0) [*8])
    else $error("message dropped too early");
  AST_NET_CAUSE: assert property ($changed(net_led) |-> since_q <= 8'h04)
    else $error("net indicator moved without a command");
  AST_UNMAPPED: assert property (rd_low && haddr[7:0] > OFS_SZERO |=> hrdata == 32'h0)
    else $error("unmapped read returned nonzero");
  AST_FACTOR_RST: assert property (rd_low && haddr[7:0] == OFS_FACTOR && !fac_q
                                   |=> hrdata == 32'h400)
    else $error("conversion factor reset value wrong");

  COV_NET: cover property ($rose(net_led));
  COV_MSG: cover property ($rose(msg_code != 3'h0));
  COV_FUNC: cover property ($rose(func_led));
endmodule : szt_core_sva

bind szt_core szt_core_sva #(.MS_DIV(MS_DIV)) u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .net_led, .func_led,
  .msg_code, .dac_code);

// ===== bench/szt_host.sv
// host model: ahb-lite master issuing register commands
`timescale 1ns/1ns
module szt_host (
  // bus
  input  wire logic        hclk,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : xfer
endmodule : szt_host

// ===== bench/scale_zero_tare_alibi_logic_tb_top.sv
// self-checking testbench of the weighing-function block
`timescale 1ns/1ns
module scale_zero_tare_alibi_logic_tb_top
  import szt_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        net_led;
  logic        func_led;
  logic [2:0]  msg_code;
  logic [15:0] dac_code;
  int          failures;
  int          checks_done;
  int          cyc;
  logic [31:0] seed;
  logic [31:0] q;
  logic [31:0] s1;
  logic [31:0] s2;

  szt_host host (.hclk(hclk), .hrdata(hrdata), .hreadyout(hreadyout), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  szt_core #(.MS_DIV(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .net_led(net_led),
    .func_led(func_led), .msg_code(msg_code), .dac_code(dac_code));

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : rnd

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask : rd

  // command pulse, then time for the registered outputs to follow
  task automatic cmd(input int b);
    wr(OFS_CMD, 32'h1 << b);
    repeat (3) @(posedge hclk);
  endtask : cmd

  // new raw weight, held until the stability band time has passed
  task automatic load(input logic [23:0] w);
    wr(OFS_WEIGHT, {8'h0, w});
    repeat (200) @(posedge hclk);
  endtask : load

  task automatic results();
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn     = 1'b0;
    failures    = 0;
    checks_done = 0;
    cyc         = 0;
    seed        = 32'h6b09;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    chk("net_led", {31'h0, net_led}, 32'h0);
    chk("func_led", {31'h0, func_led}, 32'h0);
    rd(OFS_FACTOR);
    chk("factor", q, 32'h400);
    rd(8'h40);
    chk("unmapped", q, 32'h0);
    wr(OFS_STAB, 32'h000a_0002);
    wr(OFS_ZLIM, 32'd5000);
    load(24'd50);
    rd(OFS_STATUS);
    chk("stable", {31'h0, q[0]}, 32'h1);
    cmd(CMD_ZERO);
    chk("msg_zero", {29'h0, msg_code}, {29'h0, SZT_MSG_ZERO});
    rd(OFS_DISP);
    chk("disp_zero", q, 32'h0);
    rd(OFS_ZERO);
    s1 = q;
    load(24'd6000);
    cmd(CMD_ZERO);
    rd(OFS_ZERO);
    chk("zero_refused", q, s1);
    load(24'd1050);
    cmd(CMD_TARE);
    chk("net_tare", {31'h0, net_led}, 32'h1);
    rd(OFS_DISP);
    chk("disp_net", q, 32'h0);
    load(24'd50);
    cmd(CMD_TARE);
    chk("net_unload", {31'h0, net_led}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = rnd(seed);
      s1 = (i == 3) ? 32'h0 : {16'h0, seed[15:1], 1'b1};
      wr(OFS_PTARE, s1);
      cmd(CMD_PTARE);
      rd(OFS_TARE);
      chk("ptare", q, s1);
      chk("net_ptare", {31'h0, net_led}, {31'h0, s1 != 0});
    end
    load(24'd1050);
    cmd(CMD_SAVE);
    rd(OFS_SAVE);
    s1 = q;
    cmd(CMD_SAVE);
    rd(OFS_SAVE);
    s2 = q;
    chk("save_ok", {31'h0, s1[31]}, 32'h1);
    chk("save_inc", {14'h0, s2[17:0]}, {14'h0, s1[17:0] + 18'h1});
    wr(OFS_CTRL, 32'h40);
    cmd(CMD_SAVE);
    rd(OFS_STATUS);
    chk("save_no", {30'h0, q[6:5]}, 32'h1);
    wr(OFS_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_HIRES + i);
      rd(OFS_STATUS);
      chk("func_on", {30'h0, func_led, q[1 + i]}, 32'h3);
      cmd(CMD_HIRES + i);
      rd(OFS_STATUS);
      chk("func_off", {30'h0, func_led, q[1 + i]}, 32'h0);
    end
    wr(OFS_CHECK, {14'h0, s2[17:0]});
    cmd(CMD_CHECK);
    rd(OFS_STATUS);
    chk("id_ok", {31'h0, q[7]}, 32'h1);
    wr(OFS_CHECK, {14'h0, s2[17:0] + 18'h5});
    cmd(CMD_CHECK);
    rd(OFS_STATUS);
    chk("id_bad", {31'h0, q[7]}, 32'h0);
    chk("msg_noid", {29'h0, msg_code}, {29'h0, SZT_MSG_NOID});
    wr(OFS_CTRL, 32'h110);
    cmd(CMD_ERASE);
    chk("dac_cur", {16'h0, dac_code}, 32'(1000 * DA_FS_CURR / 5000));
    cmd(CMD_CHECK);
    chk("msg_empty", {29'h0, msg_code}, {29'h0, SZT_MSG_EMPTY});
    wr(OFS_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    chk("dac_volt", {16'h0, dac_code}, 32'(1000 * DA_FS_VOLT / 5000));
    results();
  end
endmodule : scale_zero_tare_alibi_logic_tb_top
